// ==== rtl/smp_regs.vh ====
// Constants of the measurement-period block: source codes, defaults, timing.
// Included by every design file of the block; holds definitions only.
`ifndef SMP_REGS_VH
`define SMP_REGS_VH

// ==========================================================
// Synchronization source codes (3-bit selector)
`define SMP_SRC_NONE  3'h0
`define SMP_SRC_V1    3'h1
`define SMP_SRC_V2    3'h2
`define SMP_SRC_V3    3'h3
`define SMP_SRC_I1    3'h4
`define SMP_SRC_I2    3'h5
`define SMP_SRC_I3    3'h6
`define SMP_SRC_EXT   3'h7

// ==========================================================
// Detector defaults
`define SMP_HYS_DEF   16'h0080
`define SMP_THR_DEF   16'h0400
`define SMP_EXT_AMP   16'h4000
`define SMP_DC_SHIFT  8
`define SMP_LP_SHIFT  3

// ==========================================================
// Harmonic window length in harmonic-rate samples
`define SMP_HARM_LEN  1024

`endif

// ==== rtl/smp_zcd.v ====
// Zero-crossing detector for one synchronization source sample stream.
// Assumes signed samples on the system clock, qualified by vld_i.
`timescale 1ns/1ps
`include "smp_regs.vh"

module smp_zcd #(
  parameter         W   = 16,
  parameter [W-1:0] HYS = `SMP_HYS_DEF,
  parameter [W-1:0] THR = `SMP_THR_DEF
) (
  input  wire         clk_i,     // System clock
  input  wire         rst_n_i,   // Synchronous reset, active low
  input  wire         start_i,   // Data update interval start
  input  wire         vld_i,     // Sample valid
  input  wire [W-1:0] x_i,       // Source sample, signed
  input  wire         filt_en_i, // Frequency filter on
  output reg          rise_o,    // Rising crossing pulse
  output reg          fall_o,    // Falling crossing pulse
  output reg          amp_ok_o   // AC amplitude at or above threshold
);

  localparam X = W + 3;

  reg  signed [X-1:0] dc_q;
  reg  signed [X-1:0] lp_q;
  reg  signed [X-1:0] mx_q;
  reg  signed [X-1:0] mn_q;
  reg                 pos_q;
  wire signed [X-1:0] xe   = {{3{x_i[W-1]}}, x_i};
  wire signed [X-1:0] ac   = xe - dc_q;
  wire signed [X-1:0] dc_d = dc_q + (ac >>> `SMP_DC_SHIFT);
  wire signed [X-1:0] lp_d = lp_q + ((ac - lp_q) >>> `SMP_LP_SHIFT);
  wire signed [X-1:0] sig  = filt_en_i ? lp_q : ac;
  wire signed [X-1:0] hys  = {3'h0, HYS};
  wire signed [X-1:0] thr  = {3'h0, THR};

  // ==========================================================
  // AC coupling, optional low-pass, hysteresis comparator
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dc_q     <= {X{1'b0}};
      lp_q     <= {X{1'b0}};
      mx_q     <= {X{1'b0}};
      mn_q     <= {X{1'b0}};
      pos_q    <= 1'b0;
      rise_o   <= 1'b0;
      fall_o   <= 1'b0;
      amp_ok_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (vld_i) begin
        dc_q <= dc_d;                                        // [RULE12]
        lp_q <= lp_d;                                        // [RULE11]
        if (!pos_q && (sig > hys)) begin                     // [RULE10]
          pos_q  <= 1'b1;
          rise_o <= 1'b1;                                    // [RULE5]
        end else if (pos_q && (sig < -hys)) begin
          pos_q  <= 1'b0;
          fall_o <= 1'b1;                                    // [RULE5]
        end
      end
      if (start_i) begin
        mx_q     <= {X{1'b0}};
        mn_q     <= {X{1'b0}};
        amp_ok_o <= 1'b0;
      end else if (vld_i) begin
        if (sig > mx_q) mx_q <= sig;
        if (sig < mn_q) mn_q <= sig;
        amp_ok_o <= ((mx_q - mn_q) >= thr);                  // [RULE9]
      end
    end
  end

endmodule // smp_zcd

// ==== rtl/smp_win.v ====
// Per-element window accumulator: prefix sums, crossing snapshots, averages.
// Assumes crossing pulses from smp_zcd and one start pulse per interval.
`timescale 1ns/1ps
`include "smp_regs.vh"

module smp_win #(
  parameter W  = 16,
  parameter CW = 20
) (
  input  wire          clk_i,      // System clock
  input  wire          rst_n_i,    // Synchronous reset, active low
  input  wire          start_i,    // Interval boundary
  input  wire          vld_i,      // Sample valid
  input  wire [W-1:0]  u_i,        // Voltage sample
  input  wire [W-1:0]  i_i,        // Current sample
  input  wire          rise_i,     // Rising crossing
  input  wire          fall_i,     // Falling crossing
  input  wire          amp_ok_i,   // Amplitude detectable
  input  wire          no_src_i,   // No source selected
  output reg           res_vld_o,  // Results valid pulse
  output reg  [W-1:0]  mean_u_o,   // Mean voltage
  output reg  [W-1:0]  mean_i_o,   // Mean current
  output reg  [CW-1:0] cnt_o,      // Samples averaged
  output reg           whole_o,    // Whole interval used
  output reg           fall_pol_o, // Falling crossings chosen
  output reg  [W-1:0]  pkp_u_o,    // Positive voltage peak
  output reg  [W-1:0]  pkn_u_o,    // Negative voltage peak
  output reg  [W-1:0]  pkp_i_o,    // Positive current peak
  output reg  [W-1:0]  pkn_i_o     // Negative current peak
);

  localparam SW = W + CW;
  localparam [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

  reg         [CW-1:0] n_q;
  reg  signed [SW-1:0] su_q;
  reg  signed [SW-1:0] si_q;
  reg         [CW-1:0] fn_q [0:1];
  reg         [CW-1:0] ln_q [0:1];
  reg  signed [SW-1:0] fu_q [0:1];
  reg  signed [SW-1:0] lu_q [0:1];
  reg  signed [SW-1:0] fi_q [0:1];
  reg  signed [SW-1:0] li_q [0:1];
  reg         [1:0]    c_q  [0:1];
  reg  signed [W-1:0]  mxu_q, mnu_q, mxi_q, mni_q;
  integer              p;

  wire signed [SW-1:0] ue   = {{CW{u_i[W-1]}}, u_i};
  wire signed [SW-1:0] ie   = {{CW{i_i[W-1]}}, i_i};
  wire        [1:0]    evt  = {fall_i, rise_i};
  wire        [CW-1:0] len0 = ln_q[0] - fn_q[0];
  wire        [CW-1:0] len1 = ln_q[1] - fn_q[1];
  wire                 ok0  = (c_q[0] == 2'h2);
  wire                 ok1  = (c_q[1] == 2'h2);
  wire whole = no_src_i | ~amp_ok_i | (~ok0 & ~ok1);         // [RULE8] [RULE9] [RULE13]
  wire pick1 = ok1 & (~ok0 | (len1 > len0));                 // [RULE7]
  wire        [CW-1:0] wcnt = whole ? n_q : (pick1 ? len1 : len0);
  wire signed [SW-1:0] wsu  = whole ? su_q :
                              (pick1 ? lu_q[1] - fu_q[1] : lu_q[0] - fu_q[0]); // [RULE6]
  wire signed [SW-1:0] wsi  = whole ? si_q :
                              (pick1 ? li_q[1] - fi_q[1] : li_q[0] - fi_q[0]);

  // Signed sum over unsigned count, zero for an empty window
  function [W-1:0] f_avg;
    input signed [SW-1:0] s;
    input        [CW-1:0] c;
    reg   signed [SW-1:0] q;
    begin
      q = s / $signed({1'b0, c});
      f_avg = (c == {CW{1'b0}}) ? {W{1'b0}} : q[W-1:0];
    end
  endfunction

  // ==========================================================
  // Running sums, crossing snapshots, peaks
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      n_q  <= {CW{1'b0}};
      su_q <= {SW{1'b0}};
      si_q <= {SW{1'b0}};
      for (p = 0; p < 2; p = p + 1) begin
        fn_q[p] <= {CW{1'b0}};
        ln_q[p] <= {CW{1'b0}};
        fu_q[p] <= {SW{1'b0}};
        lu_q[p] <= {SW{1'b0}};
        fi_q[p] <= {SW{1'b0}};
        li_q[p] <= {SW{1'b0}};
        c_q[p]  <= 2'h0;
      end
      mxu_q <= MINV;
      mnu_q <= MAXV;
      mxi_q <= MINV;
      mni_q <= MAXV;
    end else if (start_i) begin
      // Fresh interval: nothing from the last one carries over
      n_q  <= vld_i ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};   // [RULE18]
      su_q <= vld_i ? ue : {SW{1'b0}};
      si_q <= vld_i ? ie : {SW{1'b0}};
      for (p = 0; p < 2; p = p + 1)
        c_q[p] <= 2'h0;                                      // [RULE18]
      mxu_q <= vld_i ? u_i : MINV;                           // [RULE16]
      mnu_q <= vld_i ? u_i : MAXV;
      mxi_q <= vld_i ? i_i : MINV;
      mni_q <= vld_i ? i_i : MAXV;
    end else begin
      if (vld_i) begin
        n_q  <= n_q + {{(CW-1){1'b0}}, 1'b1};
        su_q <= su_q + ue;                                   // [RULE2]
        si_q <= si_q + ie;
        if ($signed(u_i) > mxu_q) mxu_q <= u_i;              // [RULE16]
        if ($signed(u_i) < mnu_q) mnu_q <= u_i;
        if ($signed(i_i) > mxi_q) mxi_q <= i_i;
        if ($signed(i_i) < mni_q) mni_q <= i_i;
      end
      for (p = 0; p < 2; p = p + 1) begin
        if (evt[p]) begin
          if (c_q[p] == 2'h0) begin                          // [RULE6]
            fn_q[p] <= n_q;
            fu_q[p] <= su_q;
            fi_q[p] <= si_q;
            c_q[p]  <= 2'h1;
          end else begin
            c_q[p]  <= 2'h2;
          end
          ln_q[p] <= n_q;
          lu_q[p] <= su_q;
          li_q[p] <= si_q;
        end
      end
    end
  end

  // ==========================================================
  // Result capture at the interval boundary
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_vld_o  <= 1'b0;
      mean_u_o   <= {W{1'b0}};
      mean_i_o   <= {W{1'b0}};
      cnt_o      <= {CW{1'b0}};
      whole_o    <= 1'b0;
      fall_pol_o <= 1'b0;
      pkp_u_o    <= {W{1'b0}};
      pkn_u_o    <= {W{1'b0}};
      pkp_i_o    <= {W{1'b0}};
      pkn_i_o    <= {W{1'b0}};
    end else begin
      res_vld_o <= start_i;
      if (start_i) begin
        mean_u_o   <= f_avg(wsu, wcnt);                      // [RULE1] [RULE2]
        mean_i_o   <= f_avg(wsi, wcnt);
        cnt_o      <= wcnt;
        whole_o    <= whole;
        fall_pol_o <= ~whole & pick1;
        pkp_u_o    <= mxu_q;
        pkn_u_o    <= mnu_q;
        pkp_i_o    <= mxi_q;
        pkn_i_o    <= mni_q;
      end
    end
  end

endmodule // smp_win

// ==== rtl/smp_top.v ====
// Measurement-period block for three input elements: source selection,
// group linking, zero-crossing search and windowed averaging.
// Assumes samples and interval strobes on CLK_SYS_I; EXT_SYNC_I is a raw pin.
`timescale 1ns/1ps
`include "smp_regs.vh"

// How it works
// [RULE1] Each element's window spans whole periods of its selected source.
// [RULE2] Element results are averages of samples inside the window.
// [RULE3] Source may be any voltage, any current, external clock, or none.
// [RULE4] A source on an uninstalled element acts as no source.
// [RULE5] Crossings are mid-level passes on rising or falling slopes.
// [RULE6] Window runs from first to last same-polarity crossing in the interval.
// [RULE7] Polarity giving the longer window is picked each interval.
// [RULE8] Fewer than two crossings of both polarities gives the whole interval.
// [RULE9] AC amplitude below threshold also gives the whole interval.
// [RULE10] Hysteresis keeps small noise from adding crossings.
// [RULE11] A switchable low-pass filter precedes crossing detection.
// [RULE12] DC offset is removed before crossing detection.
// [RULE13] No source: every sample of the interval is averaged.
// [RULE14] Linked mode: one source setting for the whole wiring group.
// [RULE15] Independent mode: each element keeps its own source setting.
// [RULE16] Peaks always cover the whole interval.
// [RULE17] Harmonic window: 1024 harmonic samples from interval start.
// [RULE18] Windows are rebuilt each interval from that interval's crossings.
module smp_top #(
  parameter         W   = 16,
  parameter         CW  = 20,
  parameter [W-1:0] HYS = `SMP_HYS_DEF,
  parameter [W-1:0] THR = `SMP_THR_DEF
) (
  input  wire            CLK_SYS_I,         // System clock, 100 MHz
  input  wire            RST_N_I,           // Synchronous reset, active low
  input  wire            UPD_I,             // Data update interval start pulse
  input  wire            SMP_VLD_I,         // Sample valid strobe
  input  wire [W-1:0]    VOLTAGE_IN_1_I,    // Voltage sample, element 1
  input  wire [W-1:0]    VOLTAGE_IN_2_I,    // Voltage sample, element 2
  input  wire [W-1:0]    VOLTAGE_IN_3_I,    // Voltage sample, element 3
  input  wire [W-1:0]    CURRENT_IN_1_I,    // Current sample, element 1
  input  wire [W-1:0]    CURRENT_IN_2_I,    // Current sample, element 2
  input  wire [W-1:0]    CURRENT_IN_3_I,    // Current sample, element 3
  input  wire            EXT_SYNC_I,        // External sync clock pin
  input  wire [2:0]      INSTALLED_I,       // Installed elements mask
  input  wire [2:0]      GROUP_I,           // Elements in the wiring group
  input  wire            INDEP_I,           // Independent element configuration
  input  wire [2:0]      SRC_SEL_1_I,       // Sync source setting, element 1
  input  wire [2:0]      SRC_SEL_2_I,       // Sync source setting, element 2
  input  wire [2:0]      SRC_SEL_3_I,       // Sync source setting, element 3
  input  wire            FILT_EN_I,         // Frequency filter on
  input  wire            HARM_VLD_I,        // Harmonic-rate sample strobe
  output wire            RES_VLD_O,         // Results valid pulse
  output wire [3*W-1:0]  MEAN_U_O,          // Mean voltage per element
  output wire [3*W-1:0]  MEAN_I_O,          // Mean current per element
  output wire [3*CW-1:0] WIN_CNT_O,         // Averaged sample count per element
  output wire [2:0]      WHOLE_O,           // Whole-interval fallback per element
  output wire [2:0]      FALL_POL_O,        // Falling polarity chosen per element
  output wire [3*W-1:0]  PK_POS_U_O,        // Positive voltage peak per element
  output wire [3*W-1:0]  PK_NEG_U_O,        // Negative voltage peak per element
  output wire [3*W-1:0]  PK_POS_I_O,        // Positive current peak per element
  output wire [3*W-1:0]  PK_NEG_I_O,        // Negative current peak per element
  output reg  [8:0]      SRC_EFF_O,         // Effective source per element
  output reg             HARM_WIN_O         // Harmonic window open
);

  localparam [10:0] HARM_LAST = `SMP_HARM_LEN - 1;
  localparam [W-1:0] EXT_AMP  = `SMP_EXT_AMP;

  // ==========================================================
  // Helpers
  // Effective setting: shared within the group unless independent
  function [2:0] f_link;
    input [2:0] grp;
    input       indep;
    input [8:0] sels;
    input [1:0] e;
    reg   [1:0] lead;
    begin
      lead = grp[0] ? 2'd0 : (grp[1] ? 2'd1 : 2'd2);
      if (!indep && grp[e])
        f_link = sels[lead*3 +: 3];                          // [RULE14]
      else
        f_link = sels[e*3 +: 3];                             // [RULE15]
    end
  endfunction

  // Choices on missing elements collapse to none
  function [2:0] f_inst;
    input [2:0] s;
    input [2:0] inst;
    reg   [1:0] k;
    begin
      k = (s < `SMP_SRC_I1) ? s[1:0] - 2'd1 : s[1:0];
      if (s == `SMP_SRC_NONE || s == `SMP_SRC_EXT)
        f_inst = s;                                          // [RULE3]
      else
        f_inst = inst[k] ? s : `SMP_SRC_NONE;                // [RULE4]
    end
  endfunction

  // ==========================================================
  // External sync: three flops, level taken when stages 2 and 3 agree
  reg ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;

  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      ext_s3_q  <= 1'b0;
      ext_lvl_q <= 1'b0;
    end else begin
      ext_s1_q <= EXT_SYNC_I;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q)
        ext_lvl_q <= ext_s3_q;
    end
  end

  // ==========================================================
  // Source selection and sample alignment
  wire [8:0]   sels = {SRC_SEL_3_I, SRC_SEL_2_I, SRC_SEL_1_I};
  wire [3*W-1:0] vin = {VOLTAGE_IN_3_I, VOLTAGE_IN_2_I, VOLTAGE_IN_1_I};
  wire [3*W-1:0] cin = {CURRENT_IN_3_I, CURRENT_IN_2_I, CURRENT_IN_1_I};
  wire [W-1:0] ext_smp = ext_lvl_q ? EXT_AMP : (~EXT_AMP + {{(W-1){1'b0}}, 1'b1});
  reg  [8:0]   eff_d;
  reg  [3*W-1:0] src_q;
  reg  [3*W-1:0] u_q;
  reg  [3*W-1:0] i_q;
  reg          vld_q;
  reg          upd_q;
  integer      e;

  always @* begin
    for (e = 0; e < 3; e = e + 1)
      eff_d[e*3 +: 3] = f_inst(f_link(GROUP_I, INDEP_I, sels, e[1:0]), INSTALLED_I);
  end

  // Registering the muxed source keeps detection and sums on the same sample
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      SRC_EFF_O <= 9'h000;
      src_q     <= {3*W{1'b0}};
      u_q       <= {3*W{1'b0}};
      i_q       <= {3*W{1'b0}};
      vld_q     <= 1'b0;
      upd_q     <= 1'b0;
    end else begin
      SRC_EFF_O <= eff_d;
      vld_q     <= SMP_VLD_I;
      upd_q     <= UPD_I;
      u_q       <= vin;
      i_q       <= cin;
      for (e = 0; e < 3; e = e + 1) begin
        case (eff_d[e*3 +: 3])
          `SMP_SRC_V1, `SMP_SRC_V2, `SMP_SRC_V3:
            src_q[e*W +: W] <= vin[(eff_d[e*3 +: 2] - 2'd1)*W +: W];
          `SMP_SRC_I1, `SMP_SRC_I2, `SMP_SRC_I3:
            src_q[e*W +: W] <= cin[eff_d[e*3 +: 2]*W +: W];
          `SMP_SRC_EXT:
            src_q[e*W +: W] <= ext_smp;
          default:
            src_q[e*W +: W] <= {W{1'b0}};
        endcase
      end
    end
  end

  // ==========================================================
  // Per-element detector and window
  wire [2:0] rise, fall, amp_ok, res_vld;
  assign RES_VLD_O = res_vld[0];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_elem
      smp_zcd #(
        .W   (W),
        .HYS (HYS),
        .THR (THR)
      ) u_zcd (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (RST_N_I),
        .start_i   (upd_q),
        .vld_i     (vld_q),
        .x_i       (src_q[g*W +: W]),
        .filt_en_i (FILT_EN_I),
        .rise_o    (rise[g]),
        .fall_o    (fall[g]),
        .amp_ok_o  (amp_ok[g])
      );

      smp_win #(
        .W  (W),
        .CW (CW)
      ) u_win (
        .clk_i      (CLK_SYS_I),
        .rst_n_i    (RST_N_I),
        .start_i    (upd_q),
        .vld_i      (vld_q),
        .u_i        (u_q[g*W +: W]),
        .i_i        (i_q[g*W +: W]),
        .rise_i     (rise[g]),
        .fall_i     (fall[g]),
        .amp_ok_i   (amp_ok[g] | (SRC_EFF_O[g*3 +: 3] == `SMP_SRC_EXT)),
        .no_src_i   (SRC_EFF_O[g*3 +: 3] == `SMP_SRC_NONE), // [RULE13]
        .res_vld_o  (res_vld[g]),
        .mean_u_o   (MEAN_U_O[g*W +: W]),
        .mean_i_o   (MEAN_I_O[g*W +: W]),
        .cnt_o      (WIN_CNT_O[g*CW +: CW]),
        .whole_o    (WHOLE_O[g]),
        .fall_pol_o (FALL_POL_O[g]),
        .pkp_u_o    (PK_POS_U_O[g*W +: W]),
        .pkn_u_o    (PK_NEG_U_O[g*W +: W]),
        .pkp_i_o    (PK_POS_I_O[g*W +: W]),
        .pkn_i_o    (PK_NEG_I_O[g*W +: W])
      );
    end
  endgenerate

  // ==========================================================
  // Harmonic window: fixed count from interval start
  reg [10:0] hcnt_q;

  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      hcnt_q     <= 11'h000;
      HARM_WIN_O <= 1'b0;
    end else if (UPD_I) begin
      hcnt_q     <= 11'h000;
      HARM_WIN_O <= 1'b1;                                    // [RULE17]
    end else if (HARM_WIN_O && HARM_VLD_I) begin
      hcnt_q <= hcnt_q + 11'h001;
      if (hcnt_q == HARM_LAST)
        HARM_WIN_O <= 1'b0;                                  // [RULE17]
    end
  end

endmodule // smp_top

// ==== tb/smp_src_model.sv ====
// Sample source model: square waves on all six channels and the sync pin.
// Assumes one sample per clock; element k period 20*(k+1), sync pin period 40.
`timescale 1ns/1ps
module smp_src_model (
  input  wire        clk_i, // Clock
  input  wire [15:0] amp_i, // Amplitude
  input  wire [15:0] off_i, // Offset
  output reg         vld_o, // Strobe
  output reg  [95:0] smp_o, // V1..V3, I1..I3
  output reg         ext_o  // Sync pin
);
  integer ph = 0;
  integer k;
  reg     hi;
  initial begin
    vld_o = 1'b0;
    smp_o = 96'h0;
    ext_o = 1'b0;
  end
  // ==========================================================
  // Free-running waves
  always @(posedge clk_i) begin
    ph <= (ph + 1) % 120;
    vld_o <= 1'b1;
    ext_o <= (ph % 40) < 20;
    for (k = 0; k < 3; k = k + 1) begin
      hi = (ph % (20 * (k + 1))) < 10 * (k + 1);
      smp_o[k*16+:16] <= hi ? off_i + amp_i : off_i - amp_i;
      smp_o[(k+3)*16+:16] <= hi ? off_i + amp_i : off_i - amp_i;
    end
  end
endmodule // smp_src_model

// ==== tb/smp_top_asserts.sv ====
// Checker bound to the top module.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module smp_top_chk #(
  parameter W  = 16,
  parameter CW = 20
) (
  input wire            CLK_SYS_I,   // Clock
  input wire            RST_N_I,     // Reset
  input wire            UPD_I,       // Interval
  input wire [2:0]      INSTALLED_I, // Installed
  input wire [2:0]      GROUP_I,     // Group
  input wire            INDEP_I,     // Independent
  input wire [2:0]      SRC_SEL_2_I, // Source 2
  input wire            RES_VLD_O,   // Results
  input wire [3*W-1:0]  MEAN_U_O,    // Means
  input wire [3*CW-1:0] WIN_CNT_O,   // Counts
  input wire [2:0]      WHOLE_O,     // Fallback
  input wire [2:0]      FALL_POL_O,  // Polarity
  input wire [3*W-1:0]  PK_POS_U_O,  // Peaks
  input wire [3*W-1:0]  PK_NEG_U_O,  // Peaks
  input wire [8:0]      SRC_EFF_O,   // Sources
  input wire            HARM_WIN_O   // Harmonic
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // Interval results
  sequence upd_s;
    UPD_I;
  endsequence
  sequence res_s;
    ##2 RES_VLD_O ##1 !RES_VLD_O;
  endsequence
  res_timing_a: assert property (upd_s |-> res_s)
    else $error("results strobe late");
  res_cause_a: assert property (RES_VLD_O |-> $past(UPD_I, 2))
    else $error("results strobe without interval");
  res_hold_a: assert property (!RES_VLD_O |-> $stable(MEAN_U_O) && $stable(WIN_CNT_O))
    else $error("results changed between strobes");
  pol_whole_a: assert property ((WHOLE_O & FALL_POL_O) == 3'h0)
    else $error("polarity set on fallback");
  mean_range_a: assert property (RES_VLD_O && WIN_CNT_O[CW-1:0] != 0 |->
    $signed(MEAN_U_O[W-1:0]) <= $signed(PK_POS_U_O[W-1:0]) &&
    $signed(MEAN_U_O[W-1:0]) >= $signed(PK_NEG_U_O[W-1:0])) else $error("mean beyond peaks");
  harm_open_a: assert property (UPD_I |=> HARM_WIN_O [*8])
    else $error("harmonic window not open");
  // ==========================================================
  // Source selection
  linked_src_a: assert property ($past(RST_N_I) && !$past(INDEP_I) && $past(GROUP_I) == 3'h7
    && $past(INSTALLED_I) == 3'h7 |-> SRC_EFF_O[5:3] == SRC_EFF_O[2:0] &&
    SRC_EFF_O[8:6] == SRC_EFF_O[2:0]) else $error("group sources differ");
  indep_src_a: assert property ($past(RST_N_I) && $past(INDEP_I) && $past(INSTALLED_I) == 3'h7
    |-> SRC_EFF_O[5:3] == $past(SRC_SEL_2_I)) else $error("own source lost");
  uninst_src_a: assert property ($past(RST_N_I) && $past(INDEP_I) && $past(INSTALLED_I) == 3'h1
    |-> !(SRC_EFF_O[2:0] inside {3'h2, 3'h3, 3'h5, 3'h6})) else $error("absent source used");
endmodule // smp_top_chk

bind smp_top smp_top_chk #(.W(W), .CW(CW)) smp_top_chk_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .UPD_I(UPD_I), .INSTALLED_I(INSTALLED_I),
  .GROUP_I(GROUP_I), .INDEP_I(INDEP_I), .SRC_SEL_2_I(SRC_SEL_2_I), .RES_VLD_O(RES_VLD_O),
  .MEAN_U_O(MEAN_U_O), .WIN_CNT_O(WIN_CNT_O), .WHOLE_O(WHOLE_O), .FALL_POL_O(FALL_POL_O),
  .PK_POS_U_O(PK_POS_U_O), .PK_NEG_U_O(PK_NEG_U_O), .SRC_EFF_O(SRC_EFF_O),
  .HARM_WIN_O(HARM_WIN_O));

// ==== tb/smp_top_tb_top.sv ====
// Self-checking bench for the block.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
`include "smp_regs.vh"
module smp_top_tb_top;
  localparam integer L = 400;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         upd = 1'b0;
  reg         harm_vld = 1'b1;
  reg         filt_en = 1'b0;
  reg         indep = 1'b1;
  reg  [2:0]  installed = 3'h7;
  reg  [2:0]  group = 3'h7;
  reg  [8:0]  sel = {3'h3, 3'h2, 3'h1};
  reg  [15:0] amp = 16'h1000;
  reg  [15:0] off = 16'h0000;
  wire        vld, ext_sync, res_vld, harm_win;
  wire [95:0] smp, pk_i;
  wire [47:0] mean_u, mean_i, pk_pos_u, pk_neg_u;
  wire [59:0] win_cnt;
  wire [2:0]  whole;
  wire [8:0]  src_eff;
  wire [15:0] hi_v = off + amp;
  wire [15:0] lo_v = off - amp;
  integer     err_count = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  integer     f, c;
  smp_src_model smp_src_model_i (.clk_i(clk_sys), .amp_i(amp), .off_i(off), .vld_o(vld),
    .smp_o(smp), .ext_o(ext_sync));
  smp_top smp_top_i (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .UPD_I(upd), .SMP_VLD_I(vld),
    .VOLTAGE_IN_1_I(smp[15:0]), .VOLTAGE_IN_2_I(smp[31:16]), .VOLTAGE_IN_3_I(smp[47:32]),
    .CURRENT_IN_1_I(smp[63:48]), .CURRENT_IN_2_I(smp[79:64]), .CURRENT_IN_3_I(smp[95:80]),
    .EXT_SYNC_I(ext_sync), .INSTALLED_I(installed), .GROUP_I(group), .INDEP_I(indep),
    .SRC_SEL_1_I(sel[2:0]), .SRC_SEL_2_I(sel[5:3]), .SRC_SEL_3_I(sel[8:6]),
    .FILT_EN_I(filt_en), .HARM_VLD_I(harm_vld), .RES_VLD_O(res_vld), .MEAN_U_O(mean_u),
    .MEAN_I_O(mean_i), .WIN_CNT_O(win_cnt), .WHOLE_O(whole), .FALL_POL_O(),
    .PK_POS_U_O(pk_pos_u), .PK_NEG_U_O(pk_neg_u), .PK_POS_I_O(pk_i[47:0]),
    .PK_NEG_I_O(pk_i[95:48]),
    .SRC_EFF_O(src_eff), .HARM_WIN_O(harm_win));
  initial forever #5 clk_sys = ~clk_sys;
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task final_report;
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_cyc(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic upd_pulse;
    @(posedge clk_sys) upd <= 1'b1;
    @(posedge clk_sys) upd <= 1'b0;
  endtask
  task automatic interval(input integer n);
    upd_pulse;
    repeat (n - 2) @(posedge clk_sys);
  endtask
  // One interval settles a setting, the second is reported
  task automatic meas(input integer n);
    integer i;
    interval(n);
    interval(n);
    upd_pulse;
    for (i = 0; i < 4 && res_vld !== 1'b1; i = i + 1) wait_cyc(1);
    check("results strobe", res_vld, 1'b1);
  endtask
  function integer per_of(input integer code);
    case (code[2:0])
      `SMP_SRC_V1, `SMP_SRC_I1: per_of = 20;
      `SMP_SRC_V2, `SMP_SRC_I2, `SMP_SRC_EXT: per_of = 40;
      `SMP_SRC_V3, `SMP_SRC_I3: per_of = 60;
      default: per_of = 0;
    endcase
  endfunction
  task automatic chk_res(input integer per, input integer n);
    check("fallback", whole[0], per == 0);
    if (per == 0) check("whole count", win_cnt[19:0], n);
    else check("count modulo", win_cnt[19:0] % per, 0);
    if (per != 0) check("span", win_cnt[19:0] >= n - 3 * per, 1'b1);
    if (n % 20 == 0) check("mean u", mean_u[15:0], off);
    if (n % 20 == 0) check("mean i", mean_i[15:0], off);
    check("peak pos", pk_pos_u[15:0], hi_v);
    check("peak neg", pk_neg_u[15:0], lo_v);
    check("peak i", {pk_i[63:48], pk_i[15:0]}, {lo_v, hi_v});
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (f = 0; f < 2; f = f + 1) begin
      for (c = 0; c < 8; c = c + 1) begin
        @(posedge clk_sys);
        filt_en <= f[0];
        sel[2:0] <= c[2:0];
        meas(L);
        check("source", src_eff[2:0], c[2:0]);
        chk_res(per_of(c), L);
      end
    end
    @(posedge clk_sys);
    sel[2:0] <= `SMP_SRC_V1;
    meas(15);
    chk_res(0, 15);
    @(posedge clk_sys);
    amp <= 16'h0100;
    meas(L);
    chk_res(0, L);
    @(posedge clk_sys);
    amp <= 16'h1000;
    installed <= 3'h1;
    sel <= {3'h1, 3'h1, `SMP_SRC_V2};
    meas(L);
    check("absent source", src_eff[2:0], `SMP_SRC_NONE);
    chk_res(0, L);
    @(posedge clk_sys);
    installed <= 3'h7;
    indep <= 1'b0;
    group <= 3'h6;
    sel <= {3'h2, 3'h4, 3'h3};
    wait_cyc(3);
    check("partial group", src_eff, {3'h4, 3'h4, 3'h3});
    @(posedge clk_sys) group <= 3'h7;
    wait_cyc(3);
    check("linked group", src_eff, {3'h3, 3'h3, 3'h3});
    @(posedge clk_sys) indep <= 1'b1;
    wait_cyc(3);
    check("own sources", src_eff, {3'h2, 3'h4, 3'h3});
    @(posedge clk_sys) off <= 16'h2000;
    repeat (6) interval(L);
    meas(L);
    chk_res(60, L);
    upd_pulse;
    wait_cyc(1000);
    check("harmonic open", harm_win, 1'b1);
    wait_cyc(30);
    check("harmonic closed", harm_win, 1'b0);
    final_report;
  end
endmodule // smp_top_tb_top
